/* rtl/mac_pins_defines.vh */
// constants for the ethernet mac media port pin logic
// assumes a 100 MHz system clock; link clocks arrive as sampled inputs
// Overview of operation
// - port 0 transmit bus is eight bits; mii uses low four only
// - port 0 launches on incoming tx clock (mii) or own gigabit clock
// - transmit enable rises with first preamble and holds to frame end
// - transmit error with enable sends an invalid symbol in the frame
// - ten-bit mode: enable and error pins become code bits 8 and 9
// - gmii and ten-bit modes drive a 50 MHz gigabit transmit clock out, half the system clock
// - link indicator is low when the link is up, else high
// - activity indicator is low while transmit enable, or carrier (port 0) or receive valid (port 1), is high, else high
// - port 1 samples four-bit receive data on rising receive clock edge
// - receive error without valid, with receive data 0xe, is decoded as false carrier
// - port 1 launches four-bit transmit data on rising tx clock edge
`ifndef MAC_PINS_DEFINES_VH
`define MAC_PINS_DEFINES_VH
`define MODE_MII 2'h0
`define MODE_GMII 2'h1
`define MODE_TBI 2'h2
`define SYS_PERIOD_PS 10000
`define GTX_FREQ_MHZ 125
`define GTX_HALF_PS (500000 / `GTX_FREQ_MHZ)
`define GTX_HALF_CYC (((`GTX_HALF_PS / `SYS_PERIOD_PS) > 0) ? (`GTX_HALF_PS / `SYS_PERIOD_PS) : 1)
`define FALSE_CARRIER_CODE 4'he
`endif

/* rtl/pin_sync.v */
// two-flop synchroniser with rising-edge detect for a group of pins
// assumes inputs are asynchronous to clk_i
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] level_o,
  output wire [W-1:0] rise_o
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  reg [W-1:0] prev_reg;
  // meta_reg feeds sync_reg only
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
      prev_reg <= {W{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end
  assign level_o = sync_reg;
  assign rise_o = sync_reg & ~prev_reg;
endmodule // pin_sync
`default_nettype wire

/* rtl/mac_media_pins.v */
// media port pin logic for two mac ports: port 0 mii/gmii/ten-bit, port 1 mii
// assumes a user transmit stream per port and link status from management logic
`timescale 1ns/10ps
`default_nettype none
`include "mac_pins_defines.vh"
module mac_media_pins (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [1:0] port0_mode_i,
  input wire port0_link_up_i,
  input wire port1_link_up_i,
  input wire port0_carrier_sense_i,
  input wire port0_collision_i,
  input wire port0_tx_clock_in_i,
  input wire port0_tx_valid_i,
  input wire [9:0] port0_tx_data_i,
  input wire port0_tx_err_i,
  output reg port0_tx_taken_o,
  output reg [7:0] port0_tx_bus_o,
  output reg port0_tx_enable_o,
  output reg port0_tx_error_o,
  output reg port0_gigabit_tx_clock_out_o,
  output reg port0_carrier_o,
  output reg port0_collision_o,
  output reg port0_link_indicator_n_o,
  output reg port0_activity_indicator_n_o,
  input wire port1_carrier_sense_i,
  input wire port1_collision_i,
  input wire port1_tx_clock_in_i,
  input wire port1_rx_clock_in_i,
  input wire [3:0] port1_rx_bus_i,
  input wire port1_rx_valid_i,
  input wire port1_rx_error_i,
  input wire port1_tx_valid_i,
  input wire [7:0] port1_tx_data_i,
  input wire port1_tx_err_i,
  output reg port1_tx_taken_o,
  output reg [3:0] port1_tx_bus_o,
  output reg port1_tx_enable_o,
  output reg port1_tx_error_o,
  output reg [7:0] port1_rx_byte_o,
  output reg port1_rx_byte_valid_o,
  output reg port1_rx_byte_error_o,
  output reg port1_false_carrier_o,
  output reg port1_carrier_o,
  output reg port1_collision_o,
  output reg port1_link_indicator_n_o,
  output reg port1_activity_indicator_n_o
);
  wire [2:0] p0_lvl;
  wire [2:0] p0_rise;
  wire [9:0] p1_lvl;
  wire [9:0] p1_rise;
  reg [3:0] p0_hi_reg;
  reg p0_half_reg;
  reg [3:0] p1_hi_reg;
  reg p1_half_reg;
  reg [5:0] p1_rx_prev_reg;
  reg [3:0] p1_rx_lo_reg;
  reg p1_rx_half_reg;
  reg p1_rx_err_reg;
  reg [2:0] gtx_cnt_reg;
  wire p0_gig;
  wire gtx_tick;
  wire p0_tick;
  wire p1_tx_tick;
  wire p1_rx_tick;
  wire [3:0] p1_rxd;
  wire p1_rxdv;
  wire p1_rxer;
  // half period of the gigabit clock in system cycles, cut to the counter width on purpose
  localparam [31:0] GTX_HALF = `GTX_HALF_CYC;
  localparam [2:0] GTX_LAST = GTX_HALF[2:0] - 3'h1;

  // bits: 0 carrier, 1 collision, 2 tx clock
  pin_sync #(.W(3)) sync_p0 (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({port0_tx_clock_in_i, port0_collision_i, port0_carrier_sense_i}),
    .level_o(p0_lvl),
    .rise_o(p0_rise)
  );
  // bits: 0 carrier, 1 collision, 2 tx clk, 3 rx clk, 4 rx err, 5 rx valid, 9:6 rx data
  pin_sync #(.W(10)) sync_p1 (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({port1_rx_bus_i, port1_rx_valid_i, port1_rx_error_i, port1_rx_clock_in_i,
      port1_tx_clock_in_i, port1_collision_i, port1_carrier_sense_i}),
    .level_o(p1_lvl),
    .rise_o(p1_rise)
  );

  assign p0_gig = (port0_mode_i != `MODE_MII);
  // the gigabit clock comes from a divider of the system clock, so its rate is
  // bounded by the system clock; a real gigabit port needs a dedicated 125 MHz source
  assign gtx_tick = p0_gig && !port0_gigabit_tx_clock_out_o && (gtx_cnt_reg == 3'h0);
  assign p0_tick = p0_gig ? gtx_tick : p0_rise[2];
  assign p1_tx_tick = p1_rise[2];
  assign p1_rx_tick = p1_rise[3];
  // data sampled one step before the detected edge, i.e. still stable from before the edge
  assign p1_rxd = p1_rx_prev_reg[5:2];
  assign p1_rxdv = p1_rx_prev_reg[1];
  assign p1_rxer = p1_rx_prev_reg[0];

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gtx_cnt_reg <= 3'h0;
      port0_gigabit_tx_clock_out_o <= 1'b0;
    end else if (!p0_gig) begin
      gtx_cnt_reg <= 3'h0;
      port0_gigabit_tx_clock_out_o <= 1'b0;
    end else if (gtx_cnt_reg == GTX_LAST) begin
      gtx_cnt_reg <= 3'h0;
      port0_gigabit_tx_clock_out_o <= ~port0_gigabit_tx_clock_out_o;
    end else begin
      gtx_cnt_reg <= gtx_cnt_reg + 3'h1;
    end
  end

  // port 0 transmit; user holds valid and data until taken pulses
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port0_tx_bus_o <= 8'h00;
      port0_tx_enable_o <= 1'b0;
      port0_tx_error_o <= 1'b0;
      port0_tx_taken_o <= 1'b0;
      p0_hi_reg <= 4'h0;
      p0_half_reg <= 1'b0;
    end else begin
      port0_tx_taken_o <= 1'b0;
      if (p0_tick) begin
        case (port0_mode_i)
          `MODE_MII: begin
            if (p0_half_reg) begin
              port0_tx_bus_o <= {4'h0, p0_hi_reg};
              p0_half_reg <= 1'b0;
            end else if (port0_tx_valid_i) begin
              port0_tx_bus_o <= {4'h0, port0_tx_data_i[3:0]};
              p0_hi_reg <= port0_tx_data_i[7:4];
              p0_half_reg <= 1'b1;
              port0_tx_enable_o <= 1'b1;
              port0_tx_error_o <= port0_tx_err_i;
              port0_tx_taken_o <= 1'b1;
            end else begin
              port0_tx_bus_o <= 8'h00;
              port0_tx_enable_o <= 1'b0;
              port0_tx_error_o <= 1'b0;
            end
          end
          `MODE_GMII: begin
            p0_half_reg <= 1'b0;
            port0_tx_bus_o <= port0_tx_valid_i ? port0_tx_data_i[7:0] : 8'h00;
            port0_tx_enable_o <= port0_tx_valid_i;
            port0_tx_error_o <= port0_tx_valid_i & port0_tx_err_i;
            port0_tx_taken_o <= port0_tx_valid_i;
          end
          `MODE_TBI: begin
            p0_half_reg <= 1'b0;
            if (port0_tx_valid_i) begin
              {port0_tx_error_o, port0_tx_enable_o, port0_tx_bus_o} <= port0_tx_data_i;
              port0_tx_taken_o <= 1'b1;
            end
          end
          default: begin
            p0_half_reg <= 1'b0;
            port0_tx_bus_o <= 8'h00;
            port0_tx_enable_o <= 1'b0;
            port0_tx_error_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // port 1 transmit, nibbles low first
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port1_tx_bus_o <= 4'h0;
      port1_tx_enable_o <= 1'b0;
      port1_tx_error_o <= 1'b0;
      port1_tx_taken_o <= 1'b0;
      p1_hi_reg <= 4'h0;
      p1_half_reg <= 1'b0;
    end else begin
      port1_tx_taken_o <= 1'b0;
      if (p1_tx_tick) begin
        if (p1_half_reg) begin
          port1_tx_bus_o <= p1_hi_reg;
          p1_half_reg <= 1'b0;
        end else if (port1_tx_valid_i) begin
          port1_tx_bus_o <= port1_tx_data_i[3:0];
          p1_hi_reg <= port1_tx_data_i[7:4];
          p1_half_reg <= 1'b1;
          port1_tx_enable_o <= 1'b1;
          port1_tx_error_o <= port1_tx_err_i;
          port1_tx_taken_o <= 1'b1;
        end else begin
          port1_tx_bus_o <= 4'h0;
          port1_tx_enable_o <= 1'b0;
          port1_tx_error_o <= 1'b0;
        end
      end
    end
  end

  // port 1 receive
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p1_rx_prev_reg <= 6'h00;
      p1_rx_lo_reg <= 4'h0;
      p1_rx_half_reg <= 1'b0;
      p1_rx_err_reg <= 1'b0;
      port1_rx_byte_o <= 8'h00;
      port1_rx_byte_valid_o <= 1'b0;
      port1_rx_byte_error_o <= 1'b0;
      port1_false_carrier_o <= 1'b0;
    end else begin
      p1_rx_prev_reg <= {p1_lvl[9:6], p1_lvl[5], p1_lvl[4]};
      port1_rx_byte_valid_o <= 1'b0;
      port1_false_carrier_o <= 1'b0;
      if (p1_rx_tick) begin
        if (p1_rxdv) begin
          if (!p1_rx_half_reg) begin
            p1_rx_lo_reg <= p1_rxd;
            p1_rx_err_reg <= p1_rxer;
            p1_rx_half_reg <= 1'b1;
          end else begin
            port1_rx_byte_o <= {p1_rxd, p1_rx_lo_reg};
            port1_rx_byte_valid_o <= 1'b1;
            port1_rx_byte_error_o <= p1_rx_err_reg | p1_rxer;
            p1_rx_half_reg <= 1'b0;
          end
        end else begin
          p1_rx_half_reg <= 1'b0;
          port1_false_carrier_o <= p1_rxer && (p1_rxd == `FALSE_CARRIER_CODE);
        end
      end
    end
  end

  // status and indicators
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port0_carrier_o <= 1'b0;
      port0_collision_o <= 1'b0;
      port1_carrier_o <= 1'b0;
      port1_collision_o <= 1'b0;
      port0_link_indicator_n_o <= 1'b1;
      port1_link_indicator_n_o <= 1'b1;
      port0_activity_indicator_n_o <= 1'b1;
      port1_activity_indicator_n_o <= 1'b1;
    end else begin
      port0_carrier_o <= p0_lvl[0];
      port0_collision_o <= p0_lvl[1] & port0_tx_enable_o & ~p0_gig;
      port1_carrier_o <= p1_lvl[0];
      port1_collision_o <= p1_lvl[1] & port1_tx_enable_o;
      port0_link_indicator_n_o <= ~port0_link_up_i;
      port1_link_indicator_n_o <= ~port1_link_up_i;
      port0_activity_indicator_n_o <= ~(port0_tx_enable_o | p0_lvl[0]);
      port1_activity_indicator_n_o <= ~(port1_tx_enable_o | p1_rxdv);
    end
  end
endmodule // mac_media_pins
`default_nettype wire

/* tb/mac_media_pins_sva.sv */
// concurrent checks on the media port pins, watching top-level ports only
// assumes port 0 mode changes only while reset is low
`timescale 1ns/10ps
`default_nettype none
`include "mac_pins_defines.vh"
module mac_media_pins_sva (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] port0_mode_i,
  input wire logic port0_link_up_i,
  input wire logic port0_tx_valid_i,
  input wire logic [9:0] port0_tx_data_i,
  input wire logic port0_tx_err_i,
  input wire logic port0_tx_taken_o,
  input wire logic [7:0] port0_tx_bus_o,
  input wire logic port0_tx_enable_o,
  input wire logic port0_tx_error_o,
  input wire logic port0_gigabit_tx_clock_out_o,
  input wire logic port0_link_indicator_n_o,
  input wire logic port1_false_carrier_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire mii = port0_mode_i == `MODE_MII;
  wire gig = port0_mode_i == `MODE_GMII;
  wire tbi = port0_mode_i == `MODE_TBI;
  chk_link_follow: assert property ($past(rst_n_i) |-> port0_link_indicator_n_o == !$past(port0_link_up_i))
    else $error("link indicator does not follow link state");
  chk_gtx_idle: assert property (mii |-> !port0_gigabit_tx_clock_out_o)
    else $error("gigabit clock runs in mii mode");
  chk_gtx_toggle: assert property ((gig || tbi) && $past(rst_n_i) |-> $changed(port0_gigabit_tx_clock_out_o))
    else $error("gigabit clock stopped");
  chk_mii_upper: assert property (mii |-> port0_tx_bus_o[7:4] == 4'h0)
    else $error("upper transmit bits driven in mii mode");
  chk_gmii_word: assert property (gig && port0_tx_taken_o |-> port0_tx_enable_o && ({2'h0, port0_tx_bus_o} ==
    ($past(port0_tx_data_i) & 10'h0ff)) && port0_tx_error_o == $past(port0_tx_err_i))
    else $error("gmii word not launched as taken");
  chk_tbi_code: assert property (tbi && port0_tx_taken_o |->
    {port0_tx_error_o, port0_tx_enable_o, port0_tx_bus_o} == $past(port0_tx_data_i))
    else $error("ten-bit code mismatch");
  chk_frame_hold: assert property (gig && port0_tx_enable_o && port0_tx_valid_i |=> port0_tx_enable_o)
    else $error("enable dropped inside frame");
  chk_fc_pulse: assert property (port1_false_carrier_o |=> !port1_false_carrier_o)
    else $error("false carrier pulse too long");
  cov_gmii: cover property (gig && port0_tx_taken_o);
  cov_tbi: cover property (tbi && port0_tx_taken_o);
  cov_fc: cover property (port1_false_carrier_o);
endmodule // mac_media_pins_sva
bind mac_media_pins mac_media_pins_sva i_mac_media_pins_sva (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .port0_mode_i(port0_mode_i), .port0_link_up_i(port0_link_up_i), .port0_tx_valid_i(port0_tx_valid_i),
  .port0_tx_data_i(port0_tx_data_i), .port0_tx_err_i(port0_tx_err_i), .port0_tx_taken_o(port0_tx_taken_o),
  .port0_tx_bus_o(port0_tx_bus_o), .port0_tx_enable_o(port0_tx_enable_o), .port0_tx_error_o(port0_tx_error_o),
  .port0_gigabit_tx_clock_out_o(port0_gigabit_tx_clock_out_o),
  .port0_link_indicator_n_o(port0_link_indicator_n_o), .port1_false_carrier_o(port1_false_carrier_o));
`default_nettype wire

/* tb/phy_model.sv */
// phy side model: free running mii transmit clocks, framed receive clock and nibbles
// assumes the bench calls rx_nib back to back, off the system clock edges
`timescale 1ns/10ps
`default_nettype none
module phy_model (
  output var logic tx0_clk_o,
  output var logic tx1_clk_o,
  output var logic rx_clk_o,
  output var logic [3:0] rxd_o,
  output var logic rxdv_o,
  output var logic rxer_o,
  output wire logic crs_o
);
  initial {tx0_clk_o, tx1_clk_o, rx_clk_o, rxd_o, rxdv_o, rxer_o} = 9'h0;
  // transmit clocks run free: the mac cannot launch a nibble without them
  always #40 tx0_clk_o = ~tx0_clk_o;
  always #40 tx1_clk_o = ~tx1_clk_o;
  // port 0 receive clock at the mii rate; the block has no port 0 receive side to feed
  logic rx0_clk = 1'b0;
  always #40 rx0_clk = ~rx0_clk;
  assign crs_o = rxdv_o;
  task rx_nib(input [3:0] d, input v, input e);
    {rxd_o, rxdv_o, rxer_o} = {d, v, e};
    #40 rx_clk_o = 1'b1;
    #40 rx_clk_o = 1'b0;
  endtask
  // released data shows the inverse so a stale nibble never looks valid
  task rx_idle;
    {rxd_o, rxdv_o, rxer_o} = {~rxd_o, 2'h0};
    #80;
  endtask
endmodule // phy_model
`default_nettype wire

/* tb/tb_mac_media_pins.sv */
// self-checking bench: phy model on the far side, expectation queues per result
// assumes the defines header is on the include path
`timescale 1ns/10ps
`default_nettype none
`include "mac_pins_defines.vh"
module tb_mac_media_pins;
  logic sys_clk_i = 0, rst_n_i = 0, link0 = 0, link1 = 0, crs0 = 0, v0 = 0, e0 = 0, v1 = 0, e1 = 0, rdly = 0, lk = 0;
  logic col0 = 0, col1 = 0;
  logic [1:0] mode = 0;
  logic [9:0] d0 = 0, w;
  logic [7:0] d1 = 0, lf = 8'h60;
  logic [3:0] x, y;
  logic [9:0] q0[$], q1[$], qr[$];
  wire tk0, tk1, en0, er0, en1, er1, rbv, rbe, fc, ai0n, li1n, ai1n, t0c, t1c, rxc, rdv, rer, crs1;
  wire c0o, co0, co1, c1o;
  wire [7:0] bus0, rxb;
  wire [3:0] bus1, rxd;
  int fail_count = 0, check_count = 0, fcs = 0;
  mac_media_pins i_mac_media_pins (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .port0_mode_i(mode), .port0_link_up_i(link0),
    .port1_link_up_i(link1), .port0_carrier_sense_i(crs0), .port0_collision_i(col0), .port0_tx_clock_in_i(t0c),
    .port0_tx_valid_i(v0), .port0_tx_data_i(d0), .port0_tx_err_i(e0), .port0_tx_taken_o(tk0), .port0_tx_bus_o(bus0),
    .port0_tx_enable_o(en0), .port0_tx_error_o(er0), .port0_gigabit_tx_clock_out_o(), .port0_carrier_o(c0o),
    .port0_collision_o(co0), .port0_link_indicator_n_o(), .port0_activity_indicator_n_o(ai0n),
    .port1_carrier_sense_i(crs1), .port1_collision_i(col1), .port1_tx_clock_in_i(t1c), .port1_rx_clock_in_i(rxc),
    .port1_rx_bus_i(rxd), .port1_rx_valid_i(rdv), .port1_rx_error_i(rer), .port1_tx_valid_i(v1), .port1_tx_data_i(d1),
    .port1_tx_err_i(e1), .port1_tx_taken_o(tk1), .port1_tx_bus_o(bus1), .port1_tx_enable_o(en1),
    .port1_tx_error_o(er1), .port1_rx_byte_o(rxb), .port1_rx_byte_valid_o(rbv), .port1_rx_byte_error_o(rbe),
    .port1_false_carrier_o(fc), .port1_carrier_o(c1o), .port1_collision_o(co1), .port1_link_indicator_n_o(li1n),
    .port1_activity_indicator_n_o(ai1n));
  phy_model i_phy_model (.tx0_clk_o(t0c), .tx1_clk_o(t1c), .rx_clk_o(rxc), .rxd_o(rxd), .rxdv_o(rdv),
    .rxer_o(rer), .crs_o(crs1));
  function automatic [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  initial forever #5 sys_clk_i = ~sys_clk_i;
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task cmp(input [9:0] got, input [9:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task start(input [1:0] m);
    rst_n_i <= 1'b0;
    mode <= m;
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
  endtask
  task automatic send(input p, input [9:0] d);
    int n;
    if (p) {v1, d1, e1} <= {1'b1, d[7:0], d[8]};
    else {v0, d0, e0} <= {1'b1, d, d[8]};
    if (p) q1.push_back({4'h0, d[8], 1'b1, d[3:0]});
    else q0.push_back(mode == `MODE_TBI ? d : mode == `MODE_GMII ? {d[8], 1'b1, d[7:0]} : {d[8], 5'h10, d[3:0]});
    for (n = 0; n < 400; n++) begin
      @(posedge sys_clk_i);
      if ((p ? tk1 : tk0) === 1'b1) break;
    end
    if (n == 400) begin
      fail_count++;
      print_verdict;
    end
  endtask
  always @(posedge sys_clk_i) begin
    lf <= lfsr(lf);
    {link0, link1, lk, rdly} <= {lf[0], lf[1], link1, rst_n_i};
    if (rst_n_i && rdly) cmp(li1n, !lk);
    if (tk0 === 1'b1) cmp({er0, en0, bus0}, q0.pop_front());
    if (tk1 === 1'b1) cmp({er1, en1, bus1}, q1.pop_front());
    if (rbv === 1'b1) cmp({rbe, rxb}, qr.pop_front());
    if (fc === 1'b1) fcs++;
  end
  initial begin
    start(`MODE_GMII);
    for (int i = 0; i < 6; i++) send(0, {1'b0, lf[3], lf});
    v0 <= 1'b0;
    $display("test gmii done");
    start(`MODE_TBI);
    for (int i = 0; i < 4; i++) begin
      w = {lf[1:0], lf};
      send(0, w);
    end
    v0 <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    cmp({er0, en0, bus0}, w);
    $display("test ten-bit done");
    start(`MODE_MII);
    {crs0, col0, col1} <= 3'h7;
    fork
      for (int i = 0; i < 3; i++) send(0, {1'b0, lf[2], lf});
      for (int i = 0; i < 3; i++) send(1, {1'b0, lf[5], lf});
    join
    cmp({c0o, co0, co1, c1o, ai0n}, 10'h01c);
    {v0, v1, crs0, col0, col1} <= 5'h00;
    repeat (40) @(posedge sys_clk_i);
    cmp({ai0n, en0, en1, 3'h0, bus1}, 10'h200);
    cmp({2'h0, bus0}, 10'h000);
    $display("test mii transmit done");
    #2;
    for (int i = 0; i < 5; i++) begin
      x = 4'(i * 5 + 2);
      if (i % 2) qr.push_back({i == 3, x, y});
      y = x;
      i_phy_model.rx_nib(x, 1'b1, i == 2 || i == 3);
    end
    cmp({c1o, ai1n}, 10'h002);
    i_phy_model.rx_idle;
    i_phy_model.rx_nib(`FALSE_CARRIER_CODE, 1'b0, 1'b1);
    i_phy_model.rx_nib(4'h3, 1'b0, 1'b1);
    i_phy_model.rx_idle;
    repeat (20) @(posedge sys_clk_i);
    cmp(fcs, 1);
    cmp({c1o, ai1n}, 10'h001);
    cmp(q0.size() + q1.size() + qr.size(), 0);
    $display("test mii receive done");
    print_verdict;
  end
endmodule // tb_mac_media_pins
`default_nettype wire
